/* File: hdl/cms_top.sv */
`timescale 1ns/100ps
module cms_top
  import cms_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        cfg_we,
  input  wire logic [2:0]  cfg_sel,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic        tlb_we,
  input  wire logic        tlb_use_random,
  input  wire logic [5:0]  tlb_idx,
  input  wire logic [19:0] tlb_vpn,
  input  wire logic [19:0] tlb_pfn,
  input  wire logic        fetch_req,
  input  wire logic [31:0] fetch_vaddr,
  input  wire logic        ls_req,
  input  wire logic        ls_we,
  input  wire logic [31:0] ls_vaddr,
  input  wire logic [31:0] ls_wdata,
  input  wire logic [31:0] ls_pc,
  input  wire logic        bus_ready,
  output logic             fetch_busy,
  output logic             fetch_done,
  output logic             fetch_hit,
  output logic             fetch_fault,
  output logic [31:0]      fetch_paddr,
  output logic             ls_done,
  output logic             ls_hit,
  output logic             ls_fault,
  output logic [31:0]      ls_paddr,
  output logic [31:0]      ls_rdata,
  output logic             ls_store_ready,
  output logic [31:0]      fault_vaddr_reg,
  output logic [31:0]      exception_resume_pc,
  output logic [5:0]       random_index,
  output logic             user_mode_reg,
  output logic [7:0]       cache_ctl_reg,
  output logic             bus_wvalid,
  output logic [31:0]      bus_waddr,
  output logic [31:0]      bus_wdata
);
  logic [19:0] tlb_vpn_a [TLB_N];
  logic [11:0] tlb_msk_a [TLB_N];
  logic [19:0] tlb_pfn_a [TLB_N];
  logic [TLB_N-1:0] tlb_val_reg;
  logic [11:0] page_mask_reg;
  logic [5:0]  wired_reg;
  logic [7:0]  config_reg;
  logic [19:0] utlb_vpn [2];
  logic [11:0] utlb_msk [2];
  logic [19:0] utlb_pfn [2];
  logic [1:0]  utlb_val_reg;
  logic        utlb_vict_reg;
  logic        f_pend_reg;
  logic [31:0] f_va_reg;
  logic [IC_IDX_W-1:0] ic_idx;
  logic [18:0] ic_tag [2][1<<IC_IDX_W];
  logic [1:0]  ic_val [1<<IC_IDX_W];
  logic [(1<<IC_IDX_W)-1:0] ic_lru;
  logic [DC_IDX_W-1:0] dc_idx;
  logic [19:0] dc_tag [2][1<<DC_IDX_W];
  logic [31:0] dc_data [2][1<<DC_IDX_W];
  logic [1:0]  dc_val [1<<DC_IDX_W];
  logic [1:0]  dc_dirty [1<<DC_IDX_W];
  logic [(1<<DC_IDX_W)-1:0] dc_lru;

  // Translates one address; unmapped kernel segments bypass the buffer.
  function automatic logic [33:0] xlate(input logic [31:0] va, input logic user,
                                        input logic [TLB_N-1:0] val);
    logic        hit;
    logic [19:0] pv;
    logic [19:0] m;
    hit = 1'b0;
    pv  = '0;
    m   = '0;
    if (va[31] && user) begin
      return {2'b10, va};
    end
    if (va[31:29] == SEG_KCACHED || va[31:29] == SEG_KUNCACH) begin
      return {1'b0, va[31:29] == SEG_KCACHED, va & UNMAP_MASK};
    end
    for (int i = 0; i < TLB_N; i++) begin
      m = {8'h00, tlb_msk_a[i]};
      if (val[i] && (((va[31:PG_OFF] ^ tlb_vpn_a[i]) & ~m) == '0)) begin
        hit = 1'b1;
        pv  = (tlb_pfn_a[i] & ~m) | (va[31:PG_OFF] & m);
      end
    end
    return hit ? {2'b01, pv, va[PG_OFF-1:0]} : {2'b10, va};
  endfunction

  logic [33:0] ls_x;
  logic [33:0] f_x;
  logic        u_hit;
  logic [19:0] u_pv;
  logic [19:0] um;
  // The lookups sit in always_comb so a rewritten entry wakes them, not only a new argument.
  always_comb begin
    ls_x = xlate(ls_vaddr, user_mode_reg, tlb_val_reg);
    f_x  = xlate(f_va_reg, user_mode_reg, tlb_val_reg);
  end

  always_comb begin
    u_hit = 1'b0;
    u_pv  = '0;
    um    = '0;
    for (int j = 0; j < 2; j++) begin
      um = {8'h00, utlb_msk[j]};
      if (utlb_val_reg[j] && !fetch_vaddr[31]
          && (((fetch_vaddr[31:PG_OFF] ^ utlb_vpn[j]) & ~um) == '0)) begin
        u_hit = 1'b1;
        u_pv  = (utlb_pfn[j] & ~um) | (fetch_vaddr[31:PG_OFF] & um);
      end
    end
  end

  // Control registers written from the pipeline's system control port.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      user_mode_reg <= 1'b0;
      page_mask_reg <= '0;
      wired_reg     <= '0;
      cache_ctl_reg <= CCTL_RST;
      config_reg    <= CONFIG_RST;
    end else if (cfg_we) begin
      case (cfg_sel)
        CFG_STATUS: user_mode_reg <= cfg_wdata[0];
        CFG_PMASK:  page_mask_reg <= cfg_wdata[MASK_W-1:0];
        CFG_WIRED:  wired_reg     <= cfg_wdata[TLB_IW-1:0];
        CFG_CCTL:   cache_ctl_reg <= cfg_wdata[7:0] & CCTL_WMASK;
        CFG_CONFIG: config_reg    <= cfg_wdata[7:0];
        default:    config_reg    <= config_reg;
      endcase
    end
  end

  // Counting down keeps the index off wired entries without a modulo.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      random_index <= RANDOM_RST;
    end else if (random_index <= wired_reg || (cfg_we && cfg_sel == CFG_WIRED)) begin
      random_index <= RANDOM_RST;
    end else begin
      random_index <= random_index - 1'b1;
    end
  end

  logic [5:0] wr_idx;
  assign wr_idx = tlb_use_random ? random_index : tlb_idx;
  always_ff @(posedge mclk) begin
    if (tlb_we) begin
      tlb_vpn_a[wr_idx] <= tlb_vpn;
      tlb_msk_a[wr_idx] <= page_mask_reg;
      tlb_pfn_a[wr_idx] <= tlb_pfn;
    end
  end

  // A buffer write flushes the micro buffer so a stale copy cannot hit.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tlb_val_reg   <= '0;
      utlb_val_reg  <= '0;
      utlb_vict_reg <= 1'b0;
    end else if (tlb_we) begin
      tlb_val_reg[wr_idx] <= 1'b1;
      utlb_val_reg        <= '0;
    end else if (f_pend_reg && f_x[32]) begin
      utlb_val_reg[utlb_vict_reg] <= 1'b1;
      utlb_vict_reg               <= !utlb_vict_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!tlb_we && f_pend_reg && f_x[32]) begin
      for (int i = 0; i < TLB_N; i++) begin
        if (tlb_val_reg[i] && (((f_va_reg[31:PG_OFF] ^ tlb_vpn_a[i])
            & ~{8'h00, tlb_msk_a[i]}) == '0)) begin
          utlb_vpn[utlb_vict_reg] <= tlb_vpn_a[i];
          utlb_msk[utlb_vict_reg] <= tlb_msk_a[i];
          utlb_pfn[utlb_vict_reg] <= tlb_pfn_a[i];
        end
      end
    end
  end

  // Fetch: micro hit answers next cycle, a micro miss one cycle later.
  logic        f_go;
  logic [33:0] f_res;
  assign f_go  = fetch_req && !f_pend_reg;
  always_comb begin
    f_res = f_pend_reg ? f_x : (u_hit ? {2'b01, u_pv, fetch_vaddr[PG_OFF-1:0]}
                                : xlate(fetch_vaddr, user_mode_reg, tlb_val_reg));
  end
  assign ic_idx = f_res[IC_OFF +: IC_IDX_W];
  logic       ic_w;
  logic [1:0] ic_h;
  assign ic_h = {ic_val[ic_idx][1] && ic_tag[1][ic_idx] == f_res[31:13],
                 ic_val[ic_idx][0] && ic_tag[0][ic_idx] == f_res[31:13]};
  assign ic_w = config_reg[CONF_ILOCK] ? 1'b1 : ic_lru[ic_idx];
  logic f_fin;
  assign f_fin = f_pend_reg || (f_go && (u_hit || fetch_vaddr[31]));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      f_pend_reg  <= 1'b0;
      f_va_reg    <= '0;
      fetch_busy  <= 1'b0;
      fetch_done  <= 1'b0;
      fetch_hit   <= 1'b0;
      fetch_fault <= 1'b0;
      fetch_paddr <= '0;
      ic_lru      <= '0;
      for (int s = 0; s < (1 << IC_IDX_W); s++) begin
        ic_val[s] <= '0;
      end
    end else begin
      f_pend_reg <= f_go && !u_hit && !fetch_vaddr[31];
      fetch_busy <= f_go && !u_hit && !fetch_vaddr[31];
      if (f_go) begin
        f_va_reg <= fetch_vaddr;
      end
      fetch_done  <= f_fin;
      fetch_fault <= f_fin && f_res[33];
      fetch_paddr <= f_res[31:0];
      fetch_hit   <= f_fin && !f_res[33] && f_res[32] && (ic_h != 2'b00);
      if (f_fin && !f_res[33] && f_res[32]) begin
        if (ic_h != 2'b00) begin
          ic_lru[ic_idx] <= !ic_h[1];
        end else begin
          ic_val[ic_idx][ic_w] <= 1'b1;
          ic_lru[ic_idx]       <= !ic_w;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (f_fin && !f_res[33] && f_res[32] && ic_h == 2'b00) begin
      ic_tag[ic_w][ic_idx] <= f_res[31:13];
    end
  end

  // Data side: one cycle per access, stores held off while the buffer is full.
  logic       wb_in_ready;
  logic       wb_push;
  logic [63:0] wb_word;
  logic       dl;
  logic [1:0] dc_h;
  logic       dc_w;
  logic       ls_go;
  logic       ls_ok;
  logic       cb;
  logic       ev;
  // A load that must evict a dirty line also waits for room, or the victim would be lost.
  assign ls_go  = ls_req && (wb_in_ready || (!ls_we && !ev));
  assign ls_ok  = ls_go && !ls_x[33];
  assign cb     = config_reg[CONF_CBACK];
  assign dc_idx = ls_x[DC_OFF +: DC_IDX_W];
  assign dc_h = {dc_val[dc_idx][1] && dc_tag[1][dc_idx] == ls_x[31:12],
                 dc_val[dc_idx][0] && dc_tag[0][dc_idx] == ls_x[31:12]};
  assign dl   = cache_ctl_reg[CCTL_DLOCK];
  assign dc_w = dl ? 1'b1 : dc_lru[dc_idx];
  assign ev   = ls_x[32] && !ls_x[33] && dc_h == 2'b00
                && dc_val[dc_idx][dc_w] && dc_dirty[dc_idx][dc_w];
  logic alloc;
  assign alloc = ls_ok && ls_x[32] && dc_h == 2'b00 && (!ls_we || cb);

  always_comb begin
    wb_push = 1'b0;
    wb_word = {ls_x[31:0], ls_wdata};
    if (ls_ok && ls_we && (!ls_x[32] || !cb)) begin
      wb_push = 1'b1;
    end else if (alloc && dc_val[dc_idx][dc_w] && dc_dirty[dc_idx][dc_w]) begin
      wb_push = 1'b1;
      wb_word = {dc_tag[dc_w][dc_idx], dc_idx, 2'b00, dc_data[dc_w][dc_idx]};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ls_done   <= 1'b0;
      ls_hit    <= 1'b0;
      ls_fault  <= 1'b0;
      ls_paddr  <= '0;
      ls_rdata  <= '0;
      dc_lru    <= '0;
      for (int s = 0; s < (1 << DC_IDX_W); s++) begin
        dc_val[s]   <= '0;
        dc_dirty[s] <= '0;
      end
    end else begin
      ls_done  <= ls_go;
      ls_fault <= ls_go && ls_x[33];
      ls_paddr <= ls_x[31:0];
      ls_hit   <= ls_ok && ls_x[32] && dc_h != 2'b00;
      ls_rdata <= dc_h[1] ? dc_data[1][dc_idx] : dc_data[0][dc_idx];
      if (ls_ok && ls_x[32] && dc_h != 2'b00) begin
        dc_lru[dc_idx] <= !dc_h[1];
        if (ls_we && cb) begin
          dc_dirty[dc_idx][dc_h[1]] <= 1'b1;
        end
      end else if (alloc) begin
        dc_val[dc_idx][dc_w]   <= 1'b1;
        dc_dirty[dc_idx][dc_w] <= ls_we;
        dc_lru[dc_idx]         <= !dc_w;
      end
    end
  end

  // Loads fill from the ls_wdata port's value too; stores fill their data.
  always_ff @(posedge mclk) begin
    if (alloc) begin
      dc_tag[dc_w][dc_idx]  <= ls_x[31:12];
      dc_data[dc_w][dc_idx] <= ls_wdata;
    end else if (ls_ok && ls_we && ls_x[32] && dc_h != 2'b00) begin
      dc_data[dc_h[1]][dc_idx] <= ls_wdata;
    end
  end

  // Fetch faults win over data faults landing in the same cycle.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fault_vaddr_reg     <= '0;
      exception_resume_pc <= '0;
    end else if (f_fin && f_res[33]) begin
      fault_vaddr_reg     <= f_pend_reg ? f_va_reg : fetch_vaddr;
      exception_resume_pc <= f_pend_reg ? f_va_reg : fetch_vaddr;
    end else if (ls_go && ls_x[33]) begin
      fault_vaddr_reg     <= ls_vaddr;
      exception_resume_pc <= ls_pc;
    end
  end

  logic        wb_ov;
  logic [63:0] wb_od;
  cms_wbuf #(.W(64), .D(WB_DEPTH)) u_wbuf (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .in_valid  (wb_push),
    .in_data   (wb_word),
    .in_ready  (wb_in_ready),
    .out_valid (wb_ov),
    .out_data  (wb_od),
    .out_ready (bus_ready && !bus_wvalid)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_wvalid     <= 1'b0;
      bus_waddr      <= '0;
      bus_wdata      <= '0;
      ls_store_ready <= 1'b0;
    end else begin
      bus_wvalid     <= wb_ov && bus_ready && !bus_wvalid;
      bus_waddr      <= wb_od[63:32];
      bus_wdata      <= wb_od[31:0];
      ls_store_ready <= wb_in_ready;
    end
  end

  property p_user_kernel;
    @(posedge mclk) disable iff (!arst_n)
      (ls_req && !ls_we && user_mode_reg && ls_vaddr[31]) |=> (ls_fault && ls_done);
  endproperty
  a_user_kernel: assert property (p_user_kernel) else $error("user reached kernel");

  property p_badaddr;
    @(posedge mclk) disable iff (!arst_n)
      (ls_go && ls_x[33] && !(f_fin && f_res[33])) |=> fault_vaddr_reg == $past(ls_vaddr);
  endproperty
  a_badaddr: assert property (p_badaddr) else $error("fault address not captured");

  property p_epc;
    @(posedge mclk) disable iff (!arst_n)
      (ls_go && ls_x[33] && !(f_fin && f_res[33])) |=> exception_resume_pc == $past(ls_pc);
  endproperty
  a_epc: assert property (p_epc) else $error("resume address lost");

  property p_random;
    @(posedge mclk) disable iff (!arst_n) random_index >= wired_reg || $changed(wired_reg);
  endproperty
  a_random: assert property (p_random) else $error("random below wired");

  property p_uncached;
    @(posedge mclk) disable iff (!arst_n)
      (ls_req && !ls_we && !user_mode_reg && ls_vaddr[31:29] == SEG_KUNCACH)
      |=> !ls_hit && !ls_fault;
  endproperty
  a_uncached: assert property (p_uncached) else $error("uncached hit");

  property p_ufetch;
    @(posedge mclk) disable iff (!arst_n)
      (f_go && !u_hit && !fetch_vaddr[31]) |=> !fetch_done ##1 fetch_done;
  endproperty
  a_ufetch: assert property (p_ufetch) else $error("micro miss timing");

  property p_dlock;
    @(posedge mclk) disable iff (!arst_n)
      (alloc && dl) |=> dc_data[0][$past(dc_idx)] == $past(dc_data[0][dc_idx]);
  endproperty
  a_dlock: assert property (p_dlock) else $error("locked way replaced");

  property p_cctl;
    @(posedge mclk) disable iff (!arst_n) (cache_ctl_reg & ~CCTL_WMASK) == '0;
  endproperty
  a_cctl: assert property (p_cctl) else $error("reserved cache bits set");
endmodule

/* File: hdl/cms_pkg.sv */
// Behaviour
// - 4 GB space: low 2 GB user region, high 2 GB kernel region.
// - Kernel region has a cached segment and an uncached direct-to-memory segment.
// - Fully associative 64-entry translation buffer, pages 4K to 16M bytes.
// - User-region fetch addresses use a 2-entry micro buffer first, full buffer on miss.
// - Load and store addresses go straight to the full translation buffer.
// - Instruction cache is 16 KB, two-way, 16-byte lines.
// - Data cache is 8 KB, two-way, 4-byte lines.
// - Each cache can lock one way so it is never replaced.
// - Cacheable stores use copy-back or write-through per configured policy.
// - Stores to memory pass a four-entry write buffer toward the bus.
// - A failed translation captures its virtual address, replacing the old one; a fetch fault wins over a data fault in the same cycle.
// - Page mask register supplies each entry's ignored address bits.
// - Cache control holds data-cache lock bits; instruction portion stays reserved.
// - Status holds user or kernel mode; user mode may not reach kernel half.
// - A taken translation fault saves the resume address.
package cms_pkg;
  localparam int          TLB_N       = 64;
  localparam int          TLB_IW      = 6;
  localparam int          VPN_W       = 20;
  localparam int          PG_OFF      = 12;
  localparam int          MASK_W      = 12;
  localparam logic [2:0]  SEG_KCACHED = 3'h4;
  localparam logic [2:0]  SEG_KUNCACH = 3'h5;
  localparam logic [31:0] UNMAP_MASK  = 32'h1fffffff;
  localparam int          IC_IDX_W    = 9;
  localparam int          IC_OFF      = 4;
  localparam int          DC_IDX_W    = 10;
  localparam int          DC_OFF      = 2;
  localparam int          WB_DEPTH    = 4;
  localparam logic [2:0]  CFG_STATUS  = 3'h0;
  localparam logic [2:0]  CFG_PMASK   = 3'h1;
  localparam logic [2:0]  CFG_WIRED   = 3'h2;
  localparam logic [2:0]  CFG_CCTL    = 3'h3;
  localparam logic [2:0]  CFG_CONFIG  = 3'h4;
  localparam logic [7:0]  CCTL_WMASK  = 8'h01;
  localparam int          CCTL_DLOCK  = 0;
  localparam int          CONF_CBACK  = 0;
  localparam int          CONF_ILOCK  = 1;
  localparam logic [7:0]  CCTL_RST    = 8'h00;
  localparam logic [7:0]  CONFIG_RST  = 8'h00;
  localparam logic [5:0]  RANDOM_RST  = 6'h3f;
endpackage

/* File: hdl/cms_wbuf.sv */
`timescale 1ns/100ps
module cms_wbuf
  import cms_pkg::*;
#(
  parameter int W = 64,
  parameter int D = WB_DEPTH
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          push;
  logic          pop;

  // The ready flag is registered, so a full buffer stalls the store port one cycle early enough.
  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b1;
      out_valid  <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
      in_ready  <= (count_reg + (AW + 1)'(push) - (AW + 1)'(pop)) != (AW + 1)'(D);
      out_valid <= (count_reg + (AW + 1)'(push) - (AW + 1)'(pop)) != '0;
    end
  end

  assign out_data = mem[rd_ptr_reg];

  property p_wb_full_blocks;
    @(posedge mclk) disable iff (!arst_n) (count_reg == (AW + 1)'(D)) |-> !in_ready;
  endproperty
  a_wb_full_blocks: assert property (p_wb_full_blocks) else $error("full buffer accepts");

  property p_wb_count;
    @(posedge mclk) disable iff (!arst_n) count_reg <= (AW + 1)'(D);
  endproperty
  a_wb_count: assert property (p_wb_count) else $error("buffer overflow");
endmodule

/* File: tb/cms_pipe_model.sv */
`timescale 1ns/100ps
module cms_pipe_model (
  input  wire logic mclk,
  output logic        fetch_req,
  output logic [31:0] fetch_vaddr,
  output logic        ls_req,
  output logic        ls_we,
  output logic [31:0] ls_vaddr,
  output logic [31:0] ls_wdata,
  output logic [31:0] ls_pc,
  input  wire logic   fetch_done,
  input  wire logic   ls_done
);
  // A request drops at the edge that takes it; held longer it would be taken twice.
  // Released address and data lines show the inverse so stale values never match.
  initial begin
    fetch_req = 1'b0;
    fetch_vaddr = 32'h0;
    ls_req = 1'b0;
    ls_we = 1'b0;
    ls_vaddr = 32'h0;
    ls_wdata = 32'h0;
    ls_pc = 32'h0;
  end
  task automatic ls_op(input logic we, input logic [31:0] va, input logic [31:0] wd,
                       input logic [31:0] pc, input int tries, output logic done);
    done = 1'b0;
    for (int i = 0; i < tries && !done; i++) begin
      @(posedge mclk);
      ls_req   <= 1'b1;
      ls_we    <= we;
      ls_vaddr <= va;
      ls_wdata <= wd;
      ls_pc    <= pc;
      @(posedge mclk);
      ls_req   <= 1'b0;
      ls_vaddr <= ~va;
      ls_wdata <= ~wd;
      #1;
      done = (ls_done === 1'b1);
    end
  endtask
  task automatic fetch_op(input logic [31:0] va, output int lat);
    lat = 0;
    @(posedge mclk);
    fetch_req   <= 1'b1;
    fetch_vaddr <= va;
    @(posedge mclk);
    fetch_req   <= 1'b0;
    fetch_vaddr <= ~va;
    for (int i = 1; i <= 3 && lat == 0; i++) begin
      #1;
      if (fetch_done === 1'b1) begin
        lat = i;
      end else begin
        @(posedge mclk);
      end
    end
  endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench
  import cms_pkg::*;
;
  logic        mclk, arst_n, cfg_we, tlb_we, tlb_use_random, bus_ready;
  logic        fetch_busy, fetch_done, fetch_hit, fetch_fault, ls_done, ls_hit, ls_fault;
  logic        ls_store_ready, user_mode_reg, bus_wvalid, fetch_req, ls_req, ls_we;
  logic [2:0]  cfg_sel;
  logic [5:0]  random_index, tlb_idx;
  logic [7:0]  cache_ctl_reg;
  logic [19:0] tlb_vpn, tlb_pfn, vp, vq, pf;
  logic [31:0] cfg_wdata, fetch_paddr, ls_paddr, ls_rdata, fault_vaddr_reg;
  logic [31:0] exception_resume_pc, bus_waddr, bus_wdata, fetch_vaddr, ls_vaddr;
  logic [31:0] ls_wdata, ls_pc, va, wd, pc, bw_a, bw_d;
  logic [31:0] wq [4];
  logic [15:0] lfsr = 16'h005e;
  logic        dn, seen;
  int          lat;
  int          num_errors = 0;
  int          checks = 0;

  cms_top i_cms_top (.mclk, .arst_n, .cfg_we, .cfg_sel, .cfg_wdata, .tlb_we, .tlb_use_random,
    .tlb_idx, .tlb_vpn, .tlb_pfn, .fetch_req, .fetch_vaddr, .ls_req, .ls_we, .ls_vaddr,
    .ls_wdata, .ls_pc, .bus_ready, .fetch_busy, .fetch_done, .fetch_hit, .fetch_fault,
    .fetch_paddr, .ls_done, .ls_hit, .ls_fault, .ls_paddr, .ls_rdata, .ls_store_ready,
    .fault_vaddr_reg, .exception_resume_pc, .random_index, .user_mode_reg, .cache_ctl_reg,
    .bus_wvalid, .bus_waddr, .bus_wdata);
  cms_pipe_model i_cms_pipe_model (.mclk, .fetch_req, .fetch_vaddr, .ls_req, .ls_we,
    .ls_vaddr, .ls_wdata, .ls_pc, .fetch_done, .ls_done);

  function automatic logic [31:0] rnd();
    for (int i = 0; i < 2; i++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      rnd = {rnd[15:0], lfsr};
    end
  endfunction
  function automatic logic [31:0] kphys(input logic [31:0] a);
    return a & UNMAP_MASK;
  endfunction
  function automatic logic [31:0] mphys(input logic [19:0] p, input logic [31:0] a);
    return {p, a[11:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cfg(input logic [2:0] s, input logic [31:0] d);
    @(posedge mclk);
    cfg_we    <= 1'b1;
    cfg_sel   <= s;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_we <= 1'b0;
    #1;
  endtask
  task automatic tlbw(input logic r, input logic [5:0] ix, input logic [19:0] v,
                      input logic [19:0] p);
    @(posedge mclk);
    tlb_we         <= 1'b1;
    tlb_use_random <= r;
    tlb_idx        <= ix;
    tlb_vpn        <= v;
    tlb_pfn        <= p;
    @(posedge mclk);
    tlb_we <= 1'b0;
    #1;
  endtask
  task automatic ld(input logic [31:0] a, input logic [31:0] d);
    i_cms_pipe_model.ls_op(1'b0, a, d, pc, 1, dn);
  endtask
  task automatic st(input logic [31:0] a, input logic [31:0] d);
    i_cms_pipe_model.ls_op(1'b1, a, d, pc, 1, dn);
  endtask
  task automatic wait_bus();
    seen = 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      @(posedge mclk);
      #1;
      if (bus_wvalid === 1'b1) begin
        seen = 1'b1;
        bw_a = bus_waddr;
        bw_d = bus_wdata;
      end
    end
  endtask
  task automatic fin(input string n);
    $display("test %s done", n);
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // The full sequence needs about 130 cycles; reaching 40000 cycles means a hang.
  initial begin
    #400000;
    num_errors++;
    test_done();
  end

  initial begin
    {arst_n, cfg_we, cfg_sel, cfg_wdata, tlb_we, tlb_use_random} = '0;
    {tlb_idx, tlb_vpn, tlb_pfn, pc} = '0;
    bus_ready = 1'b1;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    chk(random_index, 32'h3f, "random reset");
    chk(user_mode_reg, 32'h0, "mode reset");
    cfg(CFG_CCTL, 32'hffffffff);
    chk(cache_ctl_reg, 32'h1, "cache control bits");
    cfg(CFG_CCTL, 32'h0);
    fin("reset");
    repeat (3) begin
      va = rnd() & 32'h7fffffff;
      pc = rnd();
      ld(va, 32'h0);
      chk(ls_fault, 32'h1, "unmapped fault");
      @(posedge mclk);
      #1;
      chk(fault_vaddr_reg, va, "fault address");
      chk(exception_resume_pc, pc, "resume address");
    end
    fin("fault");
    va = 32'h80000000 | (rnd() & 32'h1ffffffc);
    i_cms_pipe_model.fetch_op(va, lat);
    chk(lat, 32'h1, "kernel fetch latency");
    chk(fetch_paddr, kphys(va), "kernel fetch address");
    va = 32'ha0000000 | (rnd() & 32'h1ffffffc);
    for (int i = 0; i < 2; i++) begin
      ld(va, 32'h0);
      chk(ls_hit, 32'h0, "uncached hit");
    end
    chk(ls_paddr, kphys(va), "uncached address");
    fin("segments");
    ld(32'h80000100, 32'h11111111);
    chk(ls_hit, 32'h0, "cold load");
    ld(32'h80000100, 32'h0);
    chk(ls_rdata, 32'h11111111, "load hit data");
    ld(32'h80000104, 32'h0);
    chk(ls_hit, 32'h0, "next word misses");
    ld(32'h80001100, 32'h22222222);
    cfg(CFG_CCTL, 32'h1);
    ld(32'h80002100, 32'h0);
    ld(32'h80003100, 32'h0);
    ld(32'h80000100, 32'h0);
    chk(ls_hit, 32'h1, "locked way kept");
    cfg(CFG_CCTL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      i_cms_pipe_model.fetch_op(32'h80004000 + (i == 2 ? 32'h10 : 32'(12 * i)), lat);
      chk(fetch_hit, 32'(i == 1), "instruction line");
    end
    fin("caches");
    wd = rnd();
    st(32'h80000800, wd);
    wait_bus();
    chk(seen, 32'h1, "write-through sent");
    chk(bw_a, kphys(32'h80000800), "write-through address");
    chk(bw_d, wd, "write-through data");
    cfg(CFG_CONFIG, 32'h1);
    st(32'h80000900, wd);
    wait_bus();
    chk(seen, 32'h0, "copy-back holds store");
    ld(32'h80000900, 32'h0);
    chk(ls_rdata, wd, "copy-back data");
    @(posedge mclk);
    bus_ready <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wq[i] = rnd();
      st(32'ha0000000 + 32'(4 * i), wq[i]);
      chk(dn, 32'h1, "buffered store");
    end
    st(32'ha0000010, rnd());
    chk({dn, ls_store_ready}, 32'h0, "full buffer refuses");
    @(posedge mclk);
    bus_ready <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wait_bus();
      chk(bw_a, kphys(32'ha0000000 + 32'(4 * i)), "drain order");
      chk(bw_d, wq[i], "drain data");
    end
    cfg(CFG_CONFIG, 32'h0);
    fin("writes");
    vp = 20'(rnd() & 32'h3ffff);
    pf = 20'(rnd());
    tlbw(1'b0, 6'h05, vp, pf);
    va = {vp, 12'(rnd())};
    fork
      i_cms_pipe_model.fetch_op(va, lat);
      begin
        repeat (2) @(posedge mclk);
        #1;
        chk(fetch_busy, 32'h1, "full lookup busy");
      end
    join
    chk(lat, 32'h2, "micro miss");
    chk(fetch_paddr, mphys(pf, va), "mapped fetch");
    i_cms_pipe_model.fetch_op(va, lat);
    chk(lat, 32'h1, "micro hit");
    ld(va, 32'h0);
    chk(ls_fault, 32'h0, "mapped load fault");
    chk(ls_paddr, mphys(pf, va), "mapped load");
    cfg(CFG_PMASK, 32'h3);
    vq = (vp | 20'h40000) & 20'hffffc;
    tlbw(1'b0, 6'h09, vq, pf);
    cfg(CFG_PMASK, 32'h0);
    ld({vq | 20'h3, 12'h0}, 32'h0);
    chk(ls_fault, 32'h0, "masked match");
    ld({vp ^ 20'h1, 12'h0}, 32'h0);
    chk(ls_fault, 32'h1, "exact match");
    cfg(CFG_WIRED, 32'h3c);
    repeat (6) begin
      tlbw(1'b1, 6'h00, 20'(rnd()) | 20'h80000, 20'(rnd()));
      chk(32'(random_index >= 6'h3c), 32'h1, "wired floor");
    end
    fin("translation");
    cfg(CFG_STATUS, 32'h1);
    chk(user_mode_reg, 32'h1, "user mode");
    ld(32'h80000000, 32'h0);
    chk(ls_fault, 32'h1, "user kernel access");
    i_cms_pipe_model.fetch_op(32'h80000010, lat);
    chk(fetch_fault, 32'h1, "user kernel fetch");
    chk(exception_resume_pc, 32'h80000010, "fetch resume address");
    ld(va, 32'h0);
    chk(ls_fault, 32'h0, "user region access");
    fin("mode");
    test_done();
  end
endmodule
